// *** hw/lpp_pkg.sv ***
package lpp_pkg;

    // --------------------------------------------------------------
    // datapath sizes
    // --------------------------------------------------------------
    localparam int NE = 16;
    localparam int XW = 64;
    localparam int CNT_W = 5;
    localparam int EXT_W = 5;
    localparam int SYNC_STAGES = 2;

    // --------------------------------------------------------------
    // condition flag positions in the nzcv nibble
    // --------------------------------------------------------------
    localparam int FLAG_N = 3;
    localparam int FLAG_Z = 2;
    localparam int FLAG_C = 1;
    localparam int FLAG_V = 0;

    // --------------------------------------------------------------
    // reset values
    // --------------------------------------------------------------
    localparam logic [NE-1:0] PRED_RST = 16'h0000;
    localparam logic [3:0] FLAGS_RST = 4'h0;
    localparam logic [CNT_W-1:0] COUNT_RST = 5'h00;

    // --------------------------------------------------------------
    // constraint pattern encodings for the element count operation
    // --------------------------------------------------------------
    localparam logic [4:0] PAT_POW2 = 5'h00;
    localparam logic [4:0] PAT_VL1 = 5'h01;
    localparam logic [4:0] PAT_VL8 = 5'h08;
    localparam logic [4:0] PAT_VL16 = 5'h09;
    localparam logic [4:0] PAT_VL256 = 5'h0D;
    localparam logic [4:0] PAT_MUL4 = 5'h1D;
    localparam logic [4:0] PAT_MUL3 = 5'h1E;
    localparam logic [4:0] PAT_ALL = 5'h1F;
    localparam logic [CNT_W-1:0] VL16_COUNT = 5'h10;

    // --------------------------------------------------------------
    // operations
    // --------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_COUNT_LOOP_SIGNED_LE,
        OP_COUNT_LOOP_UNSIGNED_LT,
        OP_COUNT_LOOP_UNSIGNED_LE,
        OP_COUNT_LOOP_SIGNED_LT,
        OP_BREAK_AFTER_FIRST,
        OP_BREAK_BEFORE_FIRST,
        OP_PROPAGATE_TO_NEXT_PARTITION,
        OP_PROPAGATING_BREAK_AFTER,
        OP_PROPAGATING_BREAK_BEFORE,
        OP_SET_FIRST_ACTIVE,
        OP_FIND_NEXT_ACTIVE,
        OP_TERMINATE_ON_EQUAL,
        OP_TERMINATE_ON_NOT_EQUAL,
        OP_PATTERN_COUNT
    } lpp_op_e;

endpackage

// *** hw/lpp_count_loop.sv ***
`timescale 1ns/10ps
module lpp_count_loop
    import lpp_pkg::*;
(
    // scalars
    input wire logic [XW-1:0] base,
    input wire logic [XW-1:0] limit,
    // control
    input wire lpp_op_e op,
    input wire logic [NE-1:0] gov,
    // result
    output logic [NE-1:0] pred
);

    // --------------------------------------------------------------
    // per-element compare
    // --------------------------------------------------------------
    // operands are widened so base+i never wraps: the loop ends at the
    // true limit even when the counter would overflow the scalar width
    logic is_signed;
    logic base_ext;
    logic limit_ext;
    logic [NE-1:0] holds;

    assign is_signed = (op == OP_COUNT_LOOP_SIGNED_LE) || (op == OP_COUNT_LOOP_SIGNED_LT);
    assign base_ext = is_signed & base[XW-1];
    assign limit_ext = is_signed & limit[XW-1];

    genvar i;
    generate
        for (i = 0; i < NE; i++) begin : g_elem
            logic signed [XW+EXT_W-1:0] lhs;
            logic signed [XW+EXT_W-1:0] rhs;
            assign lhs = $signed({{EXT_W{base_ext}}, base}) + $signed((XW+EXT_W)'(i));
            assign rhs = $signed({{EXT_W{limit_ext}}, limit});
            always_comb begin
                case (op)
                    OP_COUNT_LOOP_SIGNED_LE: holds[i] = (lhs <= rhs);
                    OP_COUNT_LOOP_UNSIGNED_LE: holds[i] = (lhs <= rhs);
                    default: holds[i] = (lhs < rhs);
                endcase
            end
            // true while every compare so far held, false from first failure
            assign pred[i] = gov[i] & (&holds[i:0]);
        end
    endgenerate

endmodule

// *** hw/lpp_unit.sv ***
`timescale 1ns/10ps
// Behaviour
// - loop ops give partition: active elements true until termination, false afterwards
// - counted loop compares base plus element index against limit, true until first failure
// - counted loop offers signed le, unsigned lt, unsigned le, signed lt
// - counted loop ops always write the condition flags
// - break-after keeps elements up to and including first active true source
// - break-before keeps elements strictly before first active true source
// - propagating breaks give all false unless last active of first source true
// - propagate-to-next clears destination unless last active of first source true
// - break ops use 1-bit elements, governing predicate read canonically
// - each break op has a flag-setting and a flag-preserving variant
// - set-first-active forces first active element true, 1-bit element size
// - find-next-active returns next active element after current selection
// - terminate compare signals end on equal or on not equal
// - serialized element ops always write the condition flags
// - unknown or out-of-range count pattern yields zero, never a fault
module lpp_unit
    import lpp_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // request
    input wire logic op_valid,
    input wire lpp_op_e op_code,
    input wire logic op_set_flags,
    input wire logic [NE-1:0] gov_pred,
    input wire logic [NE-1:0] src_pred_a,
    input wire logic [NE-1:0] src_pred_b,
    input wire logic [NE-1:0] dst_pred_in,
    input wire logic [XW-1:0] src_scalar_a,
    input wire logic [XW-1:0] src_scalar_b,
    input wire logic [4:0] count_pattern,
    input wire logic [3:0] flags_in,
    // result
    output logic res_valid_ff,
    output logic res_pred_we_ff,
    output logic [NE-1:0] res_pred_ff,
    output logic res_flags_we_ff,
    output logic [3:0] res_flags_ff,
    output logic res_count_we_ff,
    output logic [CNT_W-1:0] res_count_ff
);

    // --------------------------------------------------------------
    // predicate helpers
    // --------------------------------------------------------------
    // lowest set bit as a one-hot mask
    function automatic logic [NE-1:0] lowest_bit(input logic [NE-1:0] p);
        lowest_bit = p & (~p + NE'(1));
    endfunction

    // highest set bit as a one-hot mask
    function automatic logic [NE-1:0] highest_bit(input logic [NE-1:0] p);
        logic found;
        found = 1'b0;
        highest_bit = '0;
        for (int k = NE - 1; k >= 0; k--) begin
            if (p[k] && !found) begin
                highest_bit[k] = 1'b1;
                found = 1'b1;
            end
        end
    endfunction

    // true when the last active element of s is true
    function automatic logic last_active_true(input logic [NE-1:0] g, input logic [NE-1:0] s);
        last_active_true = |(highest_bit(g) & s);
    endfunction

    // break partition: incl keeps the first active true element itself
    function automatic logic [NE-1:0] break_part(input logic [NE-1:0] g, input logic [NE-1:0] s,
                                                 input logic incl);
        logic seen;
        seen = 1'b0;
        break_part = '0;
        for (int k = 0; k < NE; k++) begin
            if (g[k]) begin
                if (!incl && s[k]) begin
                    seen = 1'b1;
                end
                break_part[k] = !seen;
                if (s[k]) begin
                    seen = 1'b1;
                end
            end
        end
    endfunction

    // nzcv derived from a predicate result under its governing predicate
    function automatic logic [3:0] pred_flags(input logic [NE-1:0] g, input logic [NE-1:0] r);
        pred_flags = FLAGS_RST;
        pred_flags[FLAG_N] = |(lowest_bit(g) & r);
        pred_flags[FLAG_Z] = ~|(g & r);
        pred_flags[FLAG_C] = ~last_active_true(g, r);
        pred_flags[FLAG_V] = 1'b0;
    endfunction

    // element count for a constraint pattern at the fixed vector length
    function automatic logic [CNT_W-1:0] pattern_count(input logic [4:0] pat);
        pattern_count = COUNT_RST;
        if (pat == PAT_POW2 || pat == PAT_ALL || pat == PAT_MUL4) begin
            pattern_count = VL16_COUNT;
        end else if (pat == PAT_MUL3) begin
            pattern_count = VL16_COUNT - CNT_W'(1);
        end else if (pat >= PAT_VL1 && pat <= PAT_VL8) begin
            pattern_count = CNT_W'(pat);
        end else if (pat == PAT_VL16) begin
            pattern_count = VL16_COUNT;
        end else if (pat > PAT_VL16 && pat <= PAT_VL256) begin
            // longer than the vector: zero rather than a fault
            pattern_count = COUNT_RST;
        end
    endfunction

    // --------------------------------------------------------------
    // reset release
    // --------------------------------------------------------------
    logic [SYNC_STAGES-1:0] rst_sync_ff;
    logic rst_n;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rst_sync_ff <= '0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[SYNC_STAGES-2:0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[SYNC_STAGES-1];

    // --------------------------------------------------------------
    // counted loop
    // --------------------------------------------------------------
    logic [NE-1:0] loop_pred;

    lpp_count_loop u_count_loop (
        .base(src_scalar_a),
        .limit(src_scalar_b),
        .op(op_code),
        .gov(gov_pred),
        .pred(loop_pred)
    );

    // --------------------------------------------------------------
    // result select
    // --------------------------------------------------------------
    logic nxt_pred_we;
    logic [NE-1:0] nxt_pred;
    logic nxt_flags_we;
    logic [3:0] nxt_flags;
    logic nxt_count_we;
    logic [CNT_W-1:0] nxt_count;
    logic prop_ok;
    logic term_hit;
    logic [NE-1:0] next_mask;
    logic [NE-1:0] cur_sel;

    // the governing predicate is taken one bit per element throughout
    assign prop_ok = last_active_true(gov_pred, src_pred_a);
    assign term_hit = (op_code == OP_TERMINATE_ON_EQUAL) ? (src_scalar_a == src_scalar_b)
                                                         : (src_scalar_a != src_scalar_b);
    // active elements strictly above the highest currently selected one;
    // with nothing selected yet the first active element is the next one
    assign cur_sel = highest_bit(src_pred_a);
    assign next_mask = (src_pred_a == PRED_RST) ? gov_pred : gov_pred & ~(cur_sel | (cur_sel - NE'(1)));

    always_comb begin
        nxt_pred_we = 1'b0;
        nxt_pred = PRED_RST;
        nxt_flags_we = 1'b0;
        nxt_flags = flags_in;
        nxt_count_we = 1'b0;
        nxt_count = COUNT_RST;
        case (op_code)
            OP_COUNT_LOOP_SIGNED_LE,
            OP_COUNT_LOOP_UNSIGNED_LT,
            OP_COUNT_LOOP_UNSIGNED_LE,
            OP_COUNT_LOOP_SIGNED_LT: begin
                nxt_pred_we = 1'b1;
                nxt_pred = loop_pred;
                nxt_flags_we = 1'b1;
                nxt_flags = pred_flags(gov_pred, loop_pred);
            end
            OP_BREAK_AFTER_FIRST: begin
                nxt_pred_we = 1'b1;
                nxt_pred = break_part(gov_pred, src_pred_a, 1'b1);
            end
            OP_BREAK_BEFORE_FIRST: begin
                nxt_pred_we = 1'b1;
                nxt_pred = break_part(gov_pred, src_pred_a, 1'b0);
            end
            OP_PROPAGATING_BREAK_AFTER: begin
                nxt_pred_we = 1'b1;
                nxt_pred = prop_ok ? break_part(gov_pred, src_pred_b, 1'b1) : PRED_RST;
            end
            OP_PROPAGATING_BREAK_BEFORE: begin
                nxt_pred_we = 1'b1;
                nxt_pred = prop_ok ? break_part(gov_pred, src_pred_b, 1'b0) : PRED_RST;
            end
            OP_PROPAGATE_TO_NEXT_PARTITION: begin
                nxt_pred_we = 1'b1;
                nxt_pred = prop_ok ? dst_pred_in : PRED_RST;
            end
            OP_SET_FIRST_ACTIVE: begin
                nxt_pred_we = 1'b1;
                nxt_pred = src_pred_a | lowest_bit(gov_pred);
                nxt_flags_we = 1'b1;
                nxt_flags = pred_flags(gov_pred, nxt_pred);
            end
            OP_FIND_NEXT_ACTIVE: begin
                nxt_pred_we = 1'b1;
                nxt_pred = lowest_bit(next_mask);
                nxt_flags_we = 1'b1;
                nxt_flags = pred_flags(gov_pred, nxt_pred);
            end
            OP_TERMINATE_ON_EQUAL,
            OP_TERMINATE_ON_NOT_EQUAL: begin
                // z and c pass through; v marks "not ended and c clear"
                nxt_flags_we = 1'b1;
                nxt_flags[FLAG_N] = term_hit;
                nxt_flags[FLAG_V] = ~term_hit & ~flags_in[FLAG_C];
            end
            OP_PATTERN_COUNT: begin
                nxt_count_we = 1'b1;
                nxt_count = pattern_count(count_pattern);
            end
            default: begin
                nxt_pred_we = 1'b0;
            end
        endcase
        // break family: flags only on the flag-setting variant
        if (op_code == OP_BREAK_AFTER_FIRST || op_code == OP_BREAK_BEFORE_FIRST ||
            op_code == OP_PROPAGATING_BREAK_AFTER || op_code == OP_PROPAGATING_BREAK_BEFORE ||
            op_code == OP_PROPAGATE_TO_NEXT_PARTITION) begin
            nxt_flags_we = op_set_flags;
            nxt_flags = pred_flags(gov_pred, nxt_pred);
        end
    end

    // --------------------------------------------------------------
    // result registers
    // --------------------------------------------------------------
    // enables drop when no request is taken, so data lines may hold stale values
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            res_valid_ff <= 1'b0;
            res_pred_we_ff <= 1'b0;
            res_flags_we_ff <= 1'b0;
            res_count_we_ff <= 1'b0;
        end else begin
            res_valid_ff <= op_valid;
            res_pred_we_ff <= op_valid & nxt_pred_we;
            res_flags_we_ff <= op_valid & nxt_flags_we;
            res_count_we_ff <= op_valid & nxt_count_we;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            res_pred_ff <= PRED_RST;
            res_flags_ff <= FLAGS_RST;
            res_count_ff <= COUNT_RST;
        end else if (op_valid) begin
            res_pred_ff <= nxt_pred;
            res_flags_ff <= nxt_flags;
            res_count_ff <= nxt_count;
        end
    end

endmodule

// *** dv/lpp_flag_file.sv ***
`timescale 1ns/10ps
module lpp_flag_file
    import lpp_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // results from the unit
    input wire logic res_flags_we_ff,
    input wire logic [3:0] res_flags_ff,
    // current flags back to the unit
    output logic [3:0] flags_in
);
    logic [3:0] flags_ff;
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            flags_ff <= FLAGS_RST;
        end else if (res_flags_we_ff) begin
            flags_ff <= res_flags_ff;
        end
    end
    // bypass, else a back-to-back terminate would read stale flags
    assign flags_in = res_flags_we_ff ? res_flags_ff : flags_ff;
endmodule

// *** dv/lpp_unit_assertions.sv ***
`timescale 1ns/10ps
module lpp_unit_assertions
    import lpp_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // request
    input wire logic op_valid,
    input wire lpp_op_e op_code,
    input wire logic op_set_flags,
    input wire logic [NE-1:0] gov_pred,
    input wire logic [XW-1:0] src_scalar_a,
    input wire logic [XW-1:0] src_scalar_b,
    input wire logic [4:0] count_pattern,
    // result
    input wire logic res_valid_ff,
    input wire logic res_pred_we_ff,
    input wire logic [NE-1:0] res_pred_ff,
    input wire logic res_flags_we_ff,
    input wire logic [3:0] res_flags_ff,
    input wire logic res_count_we_ff,
    input wire logic [CNT_W-1:0] res_count_ff
);
    // ----
    // helpers
    // ----
    wire logic [NE-1:0] low_gov = gov_pred & (~gov_pred + 16'h0001);
    wire logic same = src_scalar_a == src_scalar_b;
    wire logic is_eq = op_code == OP_TERMINATE_ON_EQUAL;
    wire logic any_we = res_pred_we_ff | res_flags_we_ff | res_count_we_ff;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    sequence s_take; op_valid ##1 res_valid_ff; endsequence
    sequence s_quiet; !res_valid_ff && !any_we; endsequence
    // ----
    // properties
    // ----
    property p_latency; op_valid |-> s_take; endproperty
    a_latency: assert property (p_latency) else $error("no result one cycle after request");
    property p_quiet; !op_valid |=> s_quiet; endproperty
    a_quiet: assert property (p_quiet) else $error("result strobe without request");
    property p_loop_flags; op_valid && op_code <= OP_COUNT_LOOP_SIGNED_LT |=> res_flags_we_ff && res_pred_we_ff; endproperty
    a_loop_flags: assert property (p_loop_flags) else $error("counted op skipped flags");
    property p_serial_flags; op_valid && op_code inside {[OP_SET_FIRST_ACTIVE:OP_TERMINATE_ON_NOT_EQUAL]} |=> res_valid_ff && res_flags_we_ff; endproperty
    a_serial_flags: assert property (p_serial_flags) else $error("serial op skipped flags");
    property p_break_flags; op_valid && op_code inside {[OP_BREAK_AFTER_FIRST:OP_PROPAGATING_BREAK_BEFORE]} |=> res_flags_we_ff == $past(op_set_flags); endproperty
    a_break_flags: assert property (p_break_flags) else $error("break flag write wrong");
    property p_inactive; op_valid && op_code <= OP_BREAK_BEFORE_FIRST |=> (res_pred_ff & ~$past(gov_pred)) == 16'h0000; endproperty
    a_inactive: assert property (p_inactive) else $error("inactive element set");
    property p_prop_zero; op_valid && gov_pred == 16'h0000 && op_code inside {[OP_PROPAGATE_TO_NEXT_PARTITION:OP_PROPAGATING_BREAK_BEFORE]} |=> res_pred_ff == 16'h0000; endproperty
    a_prop_zero: assert property (p_prop_zero) else $error("propagate without active source");
    property p_first; op_valid && op_code == OP_SET_FIRST_ACTIVE |=> (res_pred_ff & $past(low_gov)) == $past(low_gov); endproperty
    a_first: assert property (p_first) else $error("first active not set");
    property p_term; op_valid && op_code inside {OP_TERMINATE_ON_EQUAL, OP_TERMINATE_ON_NOT_EQUAL} |=> !res_pred_we_ff && res_flags_ff[FLAG_N] == ($past(same) == $past(is_eq)); endproperty
    a_term: assert property (p_term) else $error("terminate result wrong");
    property p_count_zero; op_valid && op_code == OP_PATTERN_COUNT && count_pattern inside {[5'h0A:5'h1C]} |=> res_count_we_ff && res_count_ff == 5'h00; endproperty
    a_count_zero: assert property (p_count_zero) else $error("bad pattern count not zero");
endmodule
bind lpp_unit lpp_unit_assertions u_chk (.sys_clk, .resetn, .op_valid, .op_code, .op_set_flags, .gov_pred,
    .src_scalar_a, .src_scalar_b, .count_pattern, .res_valid_ff, .res_pred_we_ff, .res_pred_ff, .res_flags_we_ff,
    .res_flags_ff, .res_count_we_ff, .res_count_ff);

// *** dv/test_loop_partition_predicate_unit.sv ***
`timescale 1ns/10ps
module test_loop_partition_predicate_unit
    import lpp_pkg::*;
;
    logic sys_clk = 0, resetn = 0, op_valid = 0, op_set_flags = 0;
    lpp_op_e op_code = OP_PATTERN_COUNT;
    logic [NE-1:0] gov_pred = '0, src_pred_a = '0, src_pred_b = '0, dst_pred_in = '0, res_pred_ff, e_pr;
    logic [XW-1:0] src_scalar_a = '0, src_scalar_b = '0;
    logic [4:0] count_pattern = '0, e_ct;
    logic [3:0] flags_in, res_flags_ff, e_fl, mf = FLAGS_RST;
    logic res_valid_ff, res_pred_we_ff, res_flags_we_ff, res_count_we_ff;
    logic [CNT_W-1:0] res_count_ff;
    logic [2:0] e_we;
    int n_fail = 0, tests_run = 0;
    bit pend = 0;
    initial forever #5 sys_clk = ~sys_clk;
    lpp_unit u_dut (.sys_clk, .resetn, .op_valid, .op_code, .op_set_flags, .gov_pred, .src_pred_a, .src_pred_b,
        .dst_pred_in, .src_scalar_a, .src_scalar_b, .count_pattern, .flags_in, .res_valid_ff, .res_pred_we_ff,
        .res_pred_ff, .res_flags_we_ff, .res_flags_ff, .res_count_we_ff, .res_count_ff);
    lpp_flag_file u_flags (.sys_clk, .resetn, .res_flags_we_ff, .res_flags_ff, .flags_in);
    // ----
    // reference model
    // ----
    function automatic logic [NE-1:0] brk(logic [NE-1:0] s, logic [NE-1:0] g, bit aft);
        logic [NE-1:0] r = '0;
        bit on = 1;
        for (int i = 0; i < NE; i++) if (g[i]) begin
            if (s[i] && !aft) on = 0;
            r[i] = on;
            if (s[i]) on = 0;
        end
        return r;
    endfunction
    function automatic bit last(logic [NE-1:0] s, logic [NE-1:0] g);
        bit r = 0;
        for (int i = 0; i < NE; i++) if (g[i]) r = s[i];
        return r;
    endfunction
    function automatic logic [3:0] pf(logic [NE-1:0] r, logic [NE-1:0] g);
        bit n = 0, c = 1, f = 1;
        for (int i = 0; i < NE; i++) if (g[i]) begin
            if (f) n = r[i];
            f = 0;
            c = !r[i];
        end
        return {n, (r & g) == 16'h0000, c, 1'b0};
    endfunction
    function automatic logic [4:0] pc(logic [4:0] p);
        if (p == 5'h00 || p == 5'h09 || p == 5'h1D || p == 5'h1F) return 5'h10;
        if (p <= 5'h08) return p;
        return (p == 5'h1E) ? 5'h0F : 5'h00;
    endfunction
    task automatic predict();
        logic signed [65:0] x, y;
        logic [NE-1:0] g, a, b;
        bit ok, sg, le, hit;
        int h;
        g = gov_pred;
        a = src_pred_a;
        b = src_pred_b;
        e_we = 3'b110;
        e_ct = '0;
        e_pr = '0;
        if (op_code <= OP_COUNT_LOOP_SIGNED_LT) begin
            sg = op_code inside {OP_COUNT_LOOP_SIGNED_LE, OP_COUNT_LOOP_SIGNED_LT};
            le = op_code inside {OP_COUNT_LOOP_SIGNED_LE, OP_COUNT_LOOP_UNSIGNED_LE};
            x = {sg ? {2{src_scalar_a[63]}} : 2'b00, src_scalar_a};
            y = {sg ? {2{src_scalar_b[63]}} : 2'b00, src_scalar_b};
            ok = 1;
            for (int i = 0; i < NE; i++) begin
                ok = ok && (le ? x <= y : x < y);
                e_pr[i] = ok && g[i];
                x = x + 1;
            end
        end else case (op_code)
            OP_BREAK_AFTER_FIRST: e_pr = brk(a, g, 1);
            OP_BREAK_BEFORE_FIRST: e_pr = brk(a, g, 0);
            OP_PROPAGATE_TO_NEXT_PARTITION: e_pr = last(a, g) ? dst_pred_in : '0;
            OP_PROPAGATING_BREAK_AFTER: e_pr = last(a, g) ? brk(b, g, 1) : '0;
            OP_PROPAGATING_BREAK_BEFORE: e_pr = last(a, g) ? brk(b, g, 0) : '0;
            OP_SET_FIRST_ACTIVE: e_pr = a | (g & (~g + 16'h0001));
            OP_FIND_NEXT_ACTIVE: begin
                h = -1;
                for (int i = 0; i < NE; i++) if (a[i]) h = i;
                for (int i = NE - 1; i > h; i--) if (g[i]) e_pr = 16'h0001 << i;
            end
            OP_TERMINATE_ON_EQUAL, OP_TERMINATE_ON_NOT_EQUAL: begin
                hit = (src_scalar_a == src_scalar_b) == (op_code == OP_TERMINATE_ON_EQUAL);
                e_we = 3'b010;
                e_fl = {hit, mf[2], mf[1], !hit && !mf[1]};
            end
            default: begin
                e_we = 3'b001;
                e_ct = pc(count_pattern);
            end
        endcase
        if (op_code inside {[OP_BREAK_AFTER_FIRST:OP_PROPAGATING_BREAK_BEFORE]}) e_we[1] = op_set_flags;
        if (op_code < OP_TERMINATE_ON_EQUAL) e_fl = pf(e_pr, g);
        if (e_we[1]) mf = e_fl;
    endtask
    // ----
    // drivers and checks
    // ----
    task automatic chk(string nm, logic [NE-1:0] seen, logic [NE-1:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic fire(bit v);
        op_valid <= v;
        #1;
        if (pend) begin
            chk("strobes", 16'({res_valid_ff, res_pred_we_ff, res_flags_we_ff, res_count_we_ff}), 16'({1'b1, e_we}));
            if (e_we[2]) chk("pred", res_pred_ff, e_pr);
            if (e_we[1]) chk("flags", 16'(res_flags_ff), 16'(e_fl));
            if (e_we[0]) chk("count", 16'(res_count_ff), 16'(e_ct));
        end
        pend = v;
        if (v) predict();
    endtask
    task automatic rnd(int n);
        logic [XW-1:0] x;
        repeat (n) begin
            x = {$urandom, $urandom};
            // push the base near the signed and unsigned limits
            if ($urandom_range(0, 3) == 0) x[62:5] = '1;
            @(posedge sys_clk);
            op_code <= lpp_op_e'($urandom_range(0, 13));
            op_set_flags <= 1'($urandom);
            gov_pred <= ($urandom_range(0, 7) == 0) ? 16'h0000 : 16'($urandom);
            src_pred_a <= ($urandom_range(0, 7) == 0) ? 16'h0000 : 16'($urandom) & 16'($urandom);
            src_pred_b <= 16'($urandom) & 16'($urandom);
            dst_pred_in <= 16'($urandom);
            src_scalar_a <= x;
            src_scalar_b <= $urandom_range(0, 1) ? x + 64'($urandom_range(0, 20)) : {$urandom, $urandom};
            count_pattern <= 5'($urandom);
            fire($urandom_range(0, 3) != 0);
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ----
    // tests
    // ----
    logic [XW-1:0] lo [4] = '{64'h7FFF_FFFF_FFFF_FFFA, 64'hFFFF_FFFF_FFFF_FFF8, 64'h8000_0000_0000_0000, 64'h9};
    logic [XW-1:0] hi [4] = '{64'h7FFF_FFFF_FFFF_FFFF, 64'hFFFF_FFFF_FFFF_FFFF, 64'hFFFF_FFFF_FFFF_FFFF, 64'h3};
    initial begin
        void'($urandom(32'h9610));
        repeat (8) @(posedge sys_clk);
        resetn <= 1;
        repeat (3) @(posedge sys_clk);
        for (int k = 0; k < 16; k++) begin
            @(posedge sys_clk);
            op_code <= lpp_op_e'(k / 4);
            src_scalar_a <= lo[k % 4];
            src_scalar_b <= hi[k % 4];
            gov_pred <= k[0] ? 16'hFDBF : 16'hFFFF;
            fire(1);
        end
        $display("test counted loop limits done");
        for (int p = 0; p < 32; p++) begin
            @(posedge sys_clk);
            op_code <= OP_PATTERN_COUNT;
            count_pattern <= 5'(p);
            fire(1);
        end
        $display("test count patterns done");
        rnd(800);
        $display("test random mix done");
        @(posedge sys_clk);
        fire(1);
        @(posedge sys_clk);
        resetn <= 0;
        op_valid <= 0;
        pend = 0;
        #1;
        chk("reset pred", res_pred_ff, PRED_RST);
        chk("reset strobes", 16'({res_valid_ff, res_flags_we_ff, res_count_we_ff}), 16'h0000);
        repeat (3) @(posedge sys_clk);
        resetn <= 1;
        repeat (3) @(posedge sys_clk);
        mf = FLAGS_RST;
        rnd(200);
        @(posedge sys_clk);
        fire(0);
        $display("test reset in flight done");
        conclude();
    end
    initial begin
        #400us;
        n_fail++;
        conclude();
    end
endmodule
